/* src/tpoc_top.sv */
// Option control register with timer source, prescaler and edge logic
// Function
// - Option register at 81h, RW, resets ones
// - Top bit set disables all pull-ups
// - Edge bit picks interrupt rising or falling
// - Source bit picks pin or instruction cycles
// - Source-edge bit picks pin falling or rising
// - Assignment bit gives prescaler to watchdog
// - Timer ratio 1:2 doubling per code
// - Watchdog ratio 1:1 doubling per code
`include "tpoc_defs.svh"

module tpoc_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire tpoc_pkg::tpoc_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire tpoc_pkg::tpoc_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_latch,
  output logic [7:0] pullup_en,
  input wire logic ext_irq_pin,
  output logic ext_irq_event,
  input wire logic instr_cycle_clock,
  input wire logic ext_timer_clock_pin,
  output logic main_timer_inc,
  input wire logic watchdog_tick,
  output logic watchdog_timeout_tick
);
  import tpoc_pkg::*;

  tpoc_top_s s_r;
  tpoc_top_s s_nxt;
  tpoc_ps_if ps_if ();
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic irq_edge;
  logic pin_edge;
  logic src_tick;
  logic prescaler_assign;

  assign prescaler_assign = s_r.opt[`TPOC_PSA_BIT];
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb begin
    s_nxt = s_r;
    // Write side: address and data may arrive in either order
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `TPOC_RESP_OKAY;
      if (s_r.awaddr == `TPOC_OPT_ADDR) begin
        if (s_r.wstrb0) begin
          s_nxt.opt = s_r.wdata;
        end
      end else if (s_r.awaddr != `TPOC_STAT_ADDR) begin
        s_nxt.bresp = `TPOC_RESP_SLVERR;
      end
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Read side
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `TPOC_RESP_OKAY;
      if (s_axi_araddr == `TPOC_OPT_ADDR) begin
        s_nxt.rdata = s_r.opt;
      end else if (s_axi_araddr == `TPOC_STAT_ADDR) begin
        s_nxt.rdata = ps_if.count;
      end else begin
        s_nxt.rdata = 8'h00;
        s_nxt.rresp = `TPOC_RESP_SLVERR;
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Edge detection on the interrupt pin
    s_nxt.irq_q = ext_irq_pin;
    if (s_r.opt[`TPOC_IEDGE_BIT]) begin
      irq_edge = ext_irq_pin && !s_r.irq_q;
    end else begin
      irq_edge = !ext_irq_pin && s_r.irq_q;
    end
    s_nxt.irq_event = irq_edge;
    // Timer clock source and its active edge
    s_nxt.tck_q = ext_timer_clock_pin;
    if (s_r.opt[`TPOC_SEDGE_BIT]) begin
      pin_edge = !ext_timer_clock_pin && s_r.tck_q;
    end else begin
      pin_edge = ext_timer_clock_pin && !s_r.tck_q;
    end
    if (s_r.opt[`TPOC_CSRC_BIT]) begin
      src_tick = pin_edge;
    end else begin
      src_tick = instr_cycle_clock;
    end
    s_nxt.tmr_tick = src_tick;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.opt <= `TPOC_OPT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Only the owner of the prescaler feeds it ticks
  assign ps_if.tick = prescaler_assign ? watchdog_tick : s_r.tmr_tick;
  assign ps_if.assign_wdt = prescaler_assign;
  assign ps_if.rate = s_r.opt[`TPOC_RATE_HI:`TPOC_RATE_LO];

  tpoc_prescaler u_ps (
    .core_clk(core_clk),
    .nrst(nrst),
    .ps(ps_if.ps)
  );

  // Undivided path when the prescaler serves the other user
  assign main_timer_inc = prescaler_assign ? s_r.tmr_tick : ps_if.div_tick;
  assign watchdog_timeout_tick = prescaler_assign ? ps_if.div_tick : watchdog_tick;
  assign pullup_en = s_r.opt[`TPOC_PUD_BIT] ? 8'h00 : port_latch;

  assign ext_irq_event = s_r.irq_event;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = {24'h000000, s_r.rdata};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  reset_ones_a: assert property (
    !$past(nrst) |-> s_r.opt == `TPOC_OPT_RST)
    else $error("option register not all ones after reset");
  pullup_off_a: assert property (
    s_r.opt[`TPOC_PUD_BIT] |-> pullup_en == 8'h00)
    else $error("pull-ups enabled while disabled");
  pullup_follow_a: assert property (
    !s_r.opt[`TPOC_PUD_BIT] |-> pullup_en == port_latch)
    else $error("pull-ups do not follow latch");
  irq_rise_a: assert property (
    (s_r.opt[`TPOC_IEDGE_BIT] && ext_irq_pin && !s_r.irq_q)
    |=> ext_irq_event)
    else $error("rising interrupt edge missed");
  irq_fall_a: assert property (
    (!s_r.opt[`TPOC_IEDGE_BIT] && $past(ext_irq_pin) && !ext_irq_pin
    && $stable(s_r.opt)) |=> ext_irq_event)
    else $error("falling interrupt edge missed");
  src_cycle_a: assert property (
    (!s_r.opt[`TPOC_CSRC_BIT] && instr_cycle_clock) |=> s_r.tmr_tick)
    else $error("instruction cycle not counted");
  src_fall_a: assert property (
    (s_r.opt[`TPOC_CSRC_BIT] && s_r.opt[`TPOC_SEDGE_BIT]
    && s_r.tck_q && !ext_timer_clock_pin) |=> s_r.tmr_tick)
    else $error("falling pin edge not counted");
  tmr_bypass_a: assert property (
    (prescaler_assign && s_r.tmr_tick) |-> main_timer_inc)
    else $error("timer not undivided while prescaler on watchdog");
  src_rise_a: assert property (
    (s_r.opt[`TPOC_CSRC_BIT] && !s_r.opt[`TPOC_SEDGE_BIT]
    && !s_r.tck_q && ext_timer_clock_pin) |=> s_r.tmr_tick)
    else $error("rising pin edge not counted");
  src_pin_only_a: assert property (
    (s_r.opt[`TPOC_CSRC_BIT] && !pin_edge) |=> !s_r.tmr_tick)
    else $error("timer ticked without a pin edge");
  irq_quiet_a: assert property (
    (ext_irq_pin == s_r.irq_q) |=> !ext_irq_event)
    else $error("interrupt event without a pin edge");

  // While the timer owns the prescaler, the watchdog sees its own tick unchanged and the timer its divided tick
  wdt_bypass_a: assert property (
    !prescaler_assign |-> watchdog_timeout_tick == watchdog_tick)
    else $error("watchdog tick altered while prescaler on timer");
  tmr_divided_a: assert property (
    !prescaler_assign |-> main_timer_inc == ps_if.div_tick)
    else $error("timer not fed from prescaler");

  // Bus answers must stand until the master takes them
  bvalid_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready)
    |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before bready");
  rvalid_hold_a: assert property (
    (s_axi_rvalid && !s_axi_rready)
    |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped before rready");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  opt_keep_a: assert property (
    !(s_r.aw_got && s_r.w_got) |=> $stable(s_r.opt))
    else $error("option register changed without a write");
endmodule

/* shared/tpoc_defs.svh */
// Offsets, field positions, reset values and codes of the option block
`ifndef TPOC_DEFS_SVH
`define TPOC_DEFS_SVH

`define TPOC_OPT_IDX 8'h81
`define TPOC_STAT_IDX 8'h82
`define TPOC_OPT_ADDR ({2'b00, `TPOC_OPT_IDX, 2'b00})
`define TPOC_STAT_ADDR ({2'b00, `TPOC_STAT_IDX, 2'b00})
`define TPOC_OPT_RST 8'hff
`define TPOC_PUD_BIT 7
`define TPOC_IEDGE_BIT 6
`define TPOC_CSRC_BIT 5
`define TPOC_SEDGE_BIT 4
`define TPOC_PSA_BIT 3
`define TPOC_RATE_HI 2
`define TPOC_RATE_LO 0
`define TPOC_RESP_OKAY 2'h0
`define TPOC_RESP_SLVERR 2'h2

`endif

/* shared/tpoc_pkg.sv */
// Types of the option control block
package tpoc_pkg;
  typedef logic [11:0] tpoc_addr_t;

  typedef struct packed {
    logic [7:0] opt;
    logic aw_got;
    logic w_got;
    tpoc_addr_t awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic irq_q;
    logic tck_q;
    logic irq_event;
    logic tmr_tick;
  } tpoc_top_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic assign_q;
    logic out;
  } tpoc_ps_s;
endpackage

/* shared/tpoc_ps_if.sv */
// Link between the option logic and the shared prescaler
interface tpoc_ps_if;
  logic tick;
  logic assign_wdt;
  logic [2:0] rate;
  logic div_tick;
  logic [7:0] count;
  modport ctl (output tick, output assign_wdt, output rate,
    input div_tick, input count);
  modport ps (input tick, input assign_wdt, input rate,
    output div_tick, output count);
endinterface

/* src/tpoc_prescaler.sv */
// Shared prescaler, divides the timer or the watchdog tick
module tpoc_prescaler (
  input wire logic core_clk,
  input wire logic nrst,
  tpoc_ps_if.ps ps
);
  import tpoc_pkg::*;

  tpoc_ps_s s_r;
  tpoc_ps_s s_nxt;
  logic [3:0] shift;
  logic [8:0] m9;
  logic [7:0] mask;
  logic fire;

  always_comb begin
    // Timer ratio is twice the watchdog ratio for the same code
    shift = {1'b0, ps.rate} + {3'h0, ~ps.assign_wdt};
    m9 = (9'h001 << shift) - 9'h001;
    mask = m9[7:0];
    fire = ps.tick && ((s_r.cnt & mask) == mask);
    s_nxt = s_r;
    s_nxt.out = fire;
    s_nxt.assign_q = ps.assign_wdt;
    if (ps.tick) begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
    // Reassignment restarts the count so no stale phase leaks over
    if (ps.assign_wdt != s_r.assign_q) begin
      s_nxt.cnt = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_r <= '{cnt: 8'h00, assign_q: 1'b1, out: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ps.div_tick = s_r.out;
  assign ps.count = s_r.cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  ps_hold_a: assert property (
    (ps.tick && ((s_r.cnt & mask) != mask)) |=> !ps.div_tick)
    else $error("prescaler fired before its ratio");
  wdt_one_a: assert property (
    (ps.tick && ps.assign_wdt && ps.rate == 3'h0) |=> ps.div_tick)
    else $error("watchdog 1:1 tick missing");
  tmr_256_a: assert property (
    (ps.tick && !ps.assign_wdt && ps.rate == 3'h7 && s_r.cnt != 8'hff)
    |=> !ps.div_tick)
    else $error("timer 1:256 fired early");
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the option control block
`include "tpoc_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpoc_pkg::*;
  logic core_clk = 0, nrst = 0, irq_pin = 0, tpin = 0;
  logic instr = 0, wdog = 0, irq_ev, tinc, wto;
  tpoc_addr_t awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] port_latch = 8'h5a, pullup_en;
  int n_mismatch = 0, samples_checked = 0, n_inc, n_irq, n_wto;
  localparam tpoc_addr_t OPT = `TPOC_OPT_ADDR;
  always #25 core_clk = ~core_clk;
  tpoc_top uut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .port_latch(port_latch),
    .pullup_en(pullup_en), .ext_irq_pin(irq_pin), .ext_irq_event(irq_ev),
    .instr_cycle_clock(instr), .ext_timer_clock_pin(tpin),
    .main_timer_inc(tinc), .watchdog_tick(wdog),
    .watchdog_timeout_tick(wto));
  // Counted on the falling edge so the pulses have settled
  always @(negedge core_clk) begin
    if (tinc === 1'b1) n_inc++;
    if (irq_ev === 1'b1) n_irq++;
    if (wto === 1'b1) n_wto++;
  end
  task automatic chk(input string nm, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input tpoc_addr_t a, input logic [7:0] d,
      input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input tpoc_addr_t a, input logic [31:0] ed,
      input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rready <= 0;
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask
  task automatic zero;
    n_inc = 0;
    n_irq = 0;
    n_wto = 0;
  endtask
  task automatic ticks(input int n, input logic w);
    repeat (n) begin
      instr <= !w;
      wdog <= w;
      @(posedge core_clk);
      instr <= 0;
      wdog <= 0;
      @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask
  task automatic pin(input logic is_irq, input logic v);
    if (is_irq) irq_pin <= v;
    else tpin <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic test_reset;
    rd(OPT, 32'hff, `TPOC_RESP_OKAY);
    chk("pullup", 8'h00, pullup_en);
    rd(`TPOC_STAT_ADDR, 32'h0, `TPOC_RESP_OKAY);
    rd(12'h000, 32'h0, `TPOC_RESP_SLVERR);
    wr(12'h000, 8'h00, `TPOC_RESP_SLVERR);
    rd(OPT, 32'hff, `TPOC_RESP_OKAY);
    $display("test reset done");
  endtask
  task automatic test_pullup;
    wr(OPT, 8'h7f, `TPOC_RESP_OKAY);
    rd(OPT, 32'h7f, `TPOC_RESP_OKAY);
    chk("pullup", 8'h5a, pullup_en);
    port_latch <= 8'ha5;
    @(posedge core_clk);
    @(posedge core_clk);
    chk("pullup", 8'ha5, pullup_en);
    wr(OPT, 8'hff, `TPOC_RESP_OKAY);
    @(posedge core_clk);
    chk("pullup", 8'h00, pullup_en);
    $display("test pullup done");
  endtask
  task automatic test_irq;
    wr(OPT, 8'h88, `TPOC_RESP_OKAY);
    zero;
    pin(1, 1);
    chk("irq fall", 0, n_irq);
    pin(1, 0);
    chk("irq fall", 1, n_irq);
    wr(OPT, 8'hc8, `TPOC_RESP_OKAY);
    zero;
    pin(1, 1);
    chk("irq rise", 1, n_irq);
    pin(1, 0);
    chk("irq rise", 1, n_irq);
    $display("test irq done");
  endtask
  task automatic test_source;
    wr(OPT, 8'ha8, `TPOC_RESP_OKAY);
    zero;
    pin(0, 1);
    chk("pin rise", 1, n_inc);
    pin(0, 0);
    ticks(3, 0);
    chk("pin rise", 1, n_inc);
    wr(OPT, 8'hb8, `TPOC_RESP_OKAY);
    zero;
    pin(0, 1);
    chk("pin fall", 0, n_inc);
    pin(0, 0);
    chk("pin fall", 1, n_inc);
    $display("test source done");
  endtask
  task automatic test_timer_ratio;
    for (int c = 0; c < 8; c++) begin
      wr(OPT, 8'h88, `TPOC_RESP_OKAY);
      wr(OPT, 8'h80 | c[7:0], `TPOC_RESP_OKAY);
      zero;
      ticks(4 << c, 0);
      chk("timer div", 2, n_inc);
    end
    zero;
    ticks(3, 1);
    chk("wdt direct", 3, n_wto);
    $display("test timer ratio done");
  endtask
  task automatic test_wdt_ratio;
    for (int c = 0; c < 8; c++) begin
      wr(OPT, 8'h80, `TPOC_RESP_OKAY);
      wr(OPT, 8'h88 | c[7:0], `TPOC_RESP_OKAY);
      zero;
      ticks(2 << c, 1);
      chk("wdt div", 2, n_wto);
      ticks(3, 0);
      chk("timer 1:1", 3, n_inc);
    end
    $display("test wdt ratio done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    test_reset;
    test_pullup;
    test_irq;
    test_source;
    test_timer_ratio;
    test_wdt_ratio;
    test_done;
  end
  // Tests need about 3500 cycles; allow well over twice that
  initial begin
    #1000000;
    n_mismatch++;
    test_done;
  end
endmodule
